// File: common/cpg_pkg.sv
// package: offsets, field layout, reset values and carriers for the c3/gfx config block
package cpg_pkg;
   localparam logic [11:0] OFS_C3_POWER_CONTROL = 12'h060;
   localparam logic [11:0] OFS_MGMT_RAM_GRAPHICS_CONTROL = 12'h070;
   localparam logic [11:0] OFS_MEM_SIZE = 12'h080;
   localparam logic [11:0] OFS_BLOCK_STATUS = 12'h084;
   localparam int BIT_PWRDN_BLOCK = 16;
   localparam int BIT_FORCE_BUSY = 10;
   localparam int BIT_SREF_DISABLE = 9;
   localparam int BIT_C3_RSVD = 8;
   localparam int GMS_LSB = 6;
   localparam int USEL_LSB = 4;
   localparam int LSEL_LSB = 2;
   localparam int LOCK_BIT = 1;
   localparam int ERR_BIT = 0;
   localparam logic [31:0] C3_RESET = 32'h0001_0040;
   localparam logic [31:0] C3_WMASK = 32'h0001_06ff;
   localparam logic [7:0] MGMT_RESET = 8'h00;
   localparam logic [7:0] C3_DELAY_RESET = 8'h40;
   localparam logic [19:0] MEM_SIZE_RESET = 20'h04000;
   localparam logic [19:0] SIZE_512K_PAGES = 20'h00080;
   localparam logic [19:0] SIZE_1M_PAGES = 20'h00100;
   typedef enum logic [1:0] {
      GMS_OFF = 2'b00,
      GMS_NOMEM = 2'b01,
      GMS_512K = 2'b10,
      GMS_1M = 2'b11
   } cpg_gms_t;
   typedef struct packed {
      logic pwrdn_block;
      logic force_busy;
      logic sref_disable;
      logic [7:0] delay;
   } cpg_c3_cfg_t;
   typedef struct packed {
      logic gfx_enable;
      logic gfx_clk_en;
      logic vga_internal;
      logic [19:0] seg_base;
      logic [19:0] gfx_base;
      logic [19:0] gfx_size;
   } cpg_gfx_map_t;
endpackage : cpg_pkg

// File: core/cpg_c3_seq.sv
// c3 entry sequencer: delay count, then power-down or self-refresh entry
`timescale 1ns/1ns
module cpg_c3_seq
   import cpg_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire cpg_pkg::cpg_c3_cfg_t cfg,
   input wire logic c3_req,
   output logic mem_cke_low,
   output logic mem_self_refresh,
   output logic counting
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_LOW = 3'b100
   } cpg_c3_st_t;
   cpg_c3_st_t st;
   logic [7:0] cnt;

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= ST_IDLE;
         cnt <= 8'h00;
      end else begin
         case (st)
            ST_IDLE: begin
               if (c3_req) begin
                  cnt <= cfg.delay;
                  st <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (!c3_req) begin
                  st <= ST_IDLE;
               end else if (cnt == 8'h00) begin
                  st <= ST_LOW;
               end else begin
                  cnt <= cnt - 8'h01;
               end
            end
            ST_LOW: begin
               if (!c3_req) begin
                  st <= ST_IDLE;
               end
            end
            default: st <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mem_cke_low <= 1'b0;
         mem_self_refresh <= 1'b0;
      end else begin
         // power-down only while permitted, never before the delay expires
         mem_cke_low <= (st == ST_LOW) && !cfg.pwrdn_block;
         mem_self_refresh <= (st == ST_LOW) && !cfg.sref_disable;
      end
   end

   assign counting = (st == ST_WAIT);

   pwrdn_gate_a: assert property (@(posedge clk) disable iff (rst)
      cfg.pwrdn_block |=> !mem_cke_low)
      else $error("cke lowered while power-down blocked");
   sref_gate_a: assert property (@(posedge clk) disable iff (rst)
      $rose(mem_self_refresh) |-> !$past(cfg.sref_disable))
      else $error("self-refresh entered while disabled");
   delay_first_a: assert property (@(posedge clk) disable iff (rst)
      (st == ST_IDLE && c3_req && cfg.delay == 8'h02
         && cfg.pwrdn_block == 1'b0)
      ##1 c3_req[*4] |-> ##1 mem_cke_low)
      else $error("power-down not entered after the delay");
   delay_hold_a: assert property (@(posedge clk) disable iff (rst)
      (st == ST_WAIT && cnt != 8'h00) |=> !mem_cke_low && !mem_self_refresh)
      else $error("low-power entry before count reached zero");
endmodule : cpg_c3_seq

// File: core/cpg_config.sv
// apb register bank for c3 power control and graphics memory select
//
// Contract
// - Bit 16 clear permits lowering cke for power-down; set (reset) forbids it.
// - Bit 10 set drives the active-low graphics busy output low continuously.
// - Bit 9 clear (reset) uses self-refresh in c3; set disables it.
// - Bits 7:0 hold the c3 entry delay, 40h advised.
// - Graphics mode 00 off, 01 on no memory, 10 on 512K, 11 on 1M.
// - Graphics mode acts only outside graphics-port mode, for vga only.
// - Mode 00 disables and clock-gates graphics and forwards vga range.
// - Writing the management register never changes graphics-port mode.
// - Non-zero mode enables graphics, serves vga internally; 10 and 11 take memory.
// - Graphics memory sits directly below the top management segment.
// - Once the lock bit is set the graphics mode field is read-only.
// - Top segment size: 10 gives 512 KB, 11 gives 1 MB, else disabled.
`timescale 1ns/1ns
module cpg_config
   import cpg_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic c3_req,
   input wire logic gfx_busy_req,
   input wire logic gfx_port_mode,
   output logic mem_cke_low,
   output logic mem_self_refresh,
   output logic gfx_port_activity_n,
   output logic internal_graphics_unit_en,
   output logic internal_graphics_unit_clk_en,
   output logic vga_internal,
   output logic [19:0] top_mgmt_segment_base,
   output logic [19:0] gfx_mem_base,
   output logic [19:0] gfx_mem_size
);
   function automatic logic [31:0] strb_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      strb_merge = r;
   endfunction : strb_merge

   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a == o);
   endfunction : hit

   logic [31:0] c3_power_control;
   logic [7:0] mgmt_ram_graphics_control;
   logic [19:0] mem_size;
   logic wr_acc;
   logic rd_setup;
   logic mapped;
   logic [31:0] next_c3;
   logic [31:0] next_mgmt;
   logic [7:0] mgmt_wr;
   logic [31:0] next_top;
   logic mgmt_lock;
   logic seq_counting;
   logic [2:0] pin_sync;
   logic busy_seen;
   cpg_c3_cfg_t c3_cfg;
   cpg_gfx_map_t map;
   logic seq_cke_low;
   logic seq_sref;

   assign wr_acc = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign mapped = hit(paddr, OFS_C3_POWER_CONTROL)
      || hit(paddr, OFS_MGMT_RAM_GRAPHICS_CONTROL)
      || hit(paddr, OFS_MEM_SIZE)
      || hit(paddr, OFS_BLOCK_STATUS);
   assign mgmt_lock = mgmt_ram_graphics_control[LOCK_BIT];

   // bit 8 and other reserved bits are dropped by the write mask, so a
   // careless write cannot leave them set
   assign next_c3 = strb_merge(c3_power_control, pwdata, pstrb)
      & C3_WMASK;
   assign next_mgmt = strb_merge({24'h000000, mgmt_ram_graphics_control},
      pwdata, pstrb);
   assign next_top = strb_merge({12'h000, mem_size}, pwdata, pstrb);

   always_comb begin
      mgmt_wr = next_mgmt[7:0];
      if (mgmt_lock) begin
         // lock is sticky until reset; the gms and usel fields freeze with it
         mgmt_wr[7:GMS_LSB] = mgmt_ram_graphics_control[7:GMS_LSB];
         mgmt_wr[5:USEL_LSB] = mgmt_ram_graphics_control[5:USEL_LSB];
         mgmt_wr[LOCK_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         c3_power_control <= C3_RESET;
      end else if (wr_acc && hit(paddr, OFS_C3_POWER_CONTROL)) begin
         c3_power_control <= next_c3;
      end
   end

   // no path from this register to gfx_port_mode exists by construction
   always_ff @(posedge clk) begin
      if (rst) begin
         mgmt_ram_graphics_control <= MGMT_RESET;
      end else if (wr_acc && hit(paddr, OFS_MGMT_RAM_GRAPHICS_CONTROL)) begin
         mgmt_ram_graphics_control <= mgmt_wr;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mem_size <= MEM_SIZE_RESET;
      end else if (wr_acc && hit(paddr, OFS_MEM_SIZE)) begin
         mem_size <= next_top[19:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         case (paddr)
            OFS_C3_POWER_CONTROL: prdata <= c3_power_control;
            OFS_MGMT_RAM_GRAPHICS_CONTROL:
               prdata <= {24'h000000, mgmt_ram_graphics_control};
            OFS_MEM_SIZE: prdata <= {12'h000, mem_size};
            OFS_BLOCK_STATUS:
               prdata <= {26'h0000000, map.gfx_enable, busy_seen,
                  seq_counting, mem_self_refresh, mem_cke_low,
                  gfx_port_mode};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // one wait-free access phase: answer in the cycle penable rises
   always_ff @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pin_sync <= 3'b000;
         busy_seen <= 1'b0;
      end else begin
         pin_sync <= {pin_sync[1:0], gfx_busy_req};
         if (pin_sync[2] == pin_sync[1]) begin
            busy_seen <= pin_sync[2];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         gfx_port_activity_n <= 1'b1;
      end else begin
         gfx_port_activity_n <= !(busy_seen
            || c3_power_control[BIT_FORCE_BUSY]);
      end
   end

   assign c3_cfg.pwrdn_block = c3_power_control[BIT_PWRDN_BLOCK];
   assign c3_cfg.force_busy = c3_power_control[BIT_FORCE_BUSY];
   assign c3_cfg.sref_disable = c3_power_control[BIT_SREF_DISABLE];
   assign c3_cfg.delay = c3_power_control[7:0];

   cpg_c3_seq u_seq (
      .clk(clk),
      .rst(rst),
      .cfg(c3_cfg),
      .c3_req(c3_req),
      .mem_cke_low(seq_cke_low),
      .mem_self_refresh(seq_sref),
      .counting(seq_counting)
   );

   cpg_gfx_map u_map (
      .clk(clk),
      .rst(rst),
      .graphics_memory_select(mgmt_ram_graphics_control[7:GMS_LSB]),
      .usel(mgmt_ram_graphics_control[5:USEL_LSB]),
      .gfx_port_mode(gfx_port_mode),
      .top_of_mem(mem_size),
      .map(map)
   );

   assign mem_cke_low = seq_cke_low;
   assign mem_self_refresh = seq_sref;
   assign internal_graphics_unit_en = map.gfx_enable;
   assign internal_graphics_unit_clk_en = map.gfx_clk_en;
   assign vga_internal = map.vga_internal;
   assign top_mgmt_segment_base = map.seg_base;
   assign gfx_mem_base = map.gfx_base;
   assign gfx_mem_size = map.gfx_size;

   force_busy_a: assert property (@(posedge clk) disable iff (rst)
      c3_power_control[BIT_FORCE_BUSY] |=> !gfx_port_activity_n)
      else $error("busy output not forced low");
   rsvd_zero_a: assert property (@(posedge clk) disable iff (rst)
      c3_power_control[BIT_C3_RSVD] == 1'b0)
      else $error("reserved bit 8 stored as one");
   delay_write_a: assert property (@(posedge clk) disable iff (rst)
      wr_acc && hit(paddr, OFS_C3_POWER_CONTROL) && pstrb[0]
      |=> c3_power_control[7:0] == $past(pwdata[7:0]))
      else $error("delay field not written");
   lock_hold_a: assert property (@(posedge clk) disable iff (rst)
      mgmt_lock |=> $stable(mgmt_ram_graphics_control[7:GMS_LSB]))
      else $error("graphics mode changed while locked");
   mode_enable_a: assert property (@(posedge clk) disable iff (rst)
      !gfx_port_mode && mgmt_ram_graphics_control[7:GMS_LSB] != GMS_OFF
      ##1 !gfx_port_mode && mgmt_ram_graphics_control[7:GMS_LSB] != GMS_OFF
      |=> internal_graphics_unit_en && vga_internal)
      else $error("graphics not enabled for non-zero mode");
   size_1m_a: assert property (@(posedge clk) disable iff (rst)
      !gfx_port_mode && mgmt_ram_graphics_control[7:GMS_LSB] == GMS_1M
      |=> gfx_mem_size == SIZE_1M_PAGES)
      else $error("1M mode does not take 1M");
   seg_size_a: assert property (@(posedge clk) disable iff (rst)
      mgmt_ram_graphics_control[5:USEL_LSB] == 2'b10 ##1 $stable(mem_size)
      |-> top_mgmt_segment_base == mem_size - SIZE_512K_PAGES)
      else $error("top segment not 512 KB below top of memory");
endmodule : cpg_config

// File: core/cpg_gfx_map.sv
// graphics memory map: stolen size, placement below the top segment
`timescale 1ns/1ns
module cpg_gfx_map
   import cpg_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] graphics_memory_select,
   input wire logic [1:0] usel,
   input wire logic gfx_port_mode,
   input wire logic [19:0] top_of_mem,
   output cpg_pkg::cpg_gfx_map_t map
);
   function automatic logic [19:0] seg_pages(input logic [1:0] sel);
      case (sel)
         2'b10: seg_pages = SIZE_512K_PAGES;
         2'b11: seg_pages = SIZE_1M_PAGES;
         default: seg_pages = 20'h00000;
      endcase
   endfunction : seg_pages

   logic active;
   logic [19:0] next_seg_base;
   logic [19:0] next_size;

   // graphics mode only counts outside graphics-port mode
   assign active = !gfx_port_mode && (graphics_memory_select != GMS_OFF);
   assign next_seg_base = top_of_mem - seg_pages(usel);
   // 01 and 00 take nothing; the others use the same size coding
   assign next_size = gfx_port_mode ? 20'h00000 : seg_pages(graphics_memory_select);

   always_ff @(posedge clk) begin
      if (rst) begin
         map <= '0;
      end else begin
         map.gfx_enable <= active;
         map.gfx_clk_en <= active;
         map.vga_internal <= active;
         map.seg_base <= next_seg_base;
         map.gfx_base <= next_seg_base - next_size;
         map.gfx_size <= next_size;
      end
   end

   below_seg_a: assert property (@(posedge clk) disable iff (rst)
      ##1 map.gfx_base + map.gfx_size == map.seg_base)
      else $error("graphics region not directly below top segment");
   off_nomem_a: assert property (@(posedge clk) disable iff (rst)
      graphics_memory_select == GMS_OFF |=> map.gfx_size == 20'h00000 && !map.gfx_clk_en)
      else $error("graphics off but memory or clock still taken");
endmodule : cpg_gfx_map

// File: dv/c3_power_and_gfx_memory_config_test.sv
// testbench for the c3 power and graphics memory config block
`timescale 1ns/1ns
module c3_power_and_gfx_memory_config_test;
   import cpg_pkg::*;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic c3_req, gfx_busy_req, gfx_port_mode;
   logic mem_cke_low, mem_self_refresh, busy_n, gen, gclk, vga;
   logic [19:0] seg_base, gfx_base, gfx_size;
   int failures, n_checks;
   int g, u;

   cpg_config DUT (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .c3_req(c3_req), .gfx_busy_req(gfx_busy_req),
      .gfx_port_mode(gfx_port_mode), .mem_cke_low(mem_cke_low),
      .mem_self_refresh(mem_self_refresh), .gfx_port_activity_n(busy_n),
      .internal_graphics_unit_en(gen),
      .internal_graphics_unit_clk_en(gclk), .vga_internal(vga),
      .top_mgmt_segment_base(seg_base), .gfx_mem_base(gfx_base),
      .gfx_mem_size(gfx_size)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task complete_run;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run

   task check(input string name, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // one apb transfer; waits up to 20 cycles for pready
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      // look at the settled answer before the edge that samples it
      do begin
         @(negedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      check("pready", pready, 1'b1);
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rchk(input string name, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(name, rd, e);
   endtask : rchk

   task mchk(input logic [1:0] gm, us, input logic pm);
      logic [19:0] gs, ss;
      logic on;
      on = (gm != 2'b00) && !pm;
      gs = !on ? 20'h0 : gm == 2'b10 ? SIZE_512K_PAGES :
           gm == 2'b11 ? SIZE_1M_PAGES : 20'h0;
      ss = us == 2'b10 ? SIZE_512K_PAGES :
           us == 2'b11 ? SIZE_1M_PAGES : 20'h0;
      check("gfx_en", gen, on);
      check("gfx_clk", gclk, on);
      check("vga_int", vga, on);
      check("gfx_size", gfx_size, gs);
      check("seg_base", seg_base, MEM_SIZE_RESET - ss);
      check("gfx_base", gfx_base, MEM_SIZE_RESET - ss - gs);
   endtask : mchk

   // program the c3 register, request c3 and time the memory entry
   task c3_run(input logic [7:0] d, input logic nopd, nosr, ecke, esr);
      int n;
      apb(1'b1, OFS_C3_POWER_CONTROL, {15'h0, nopd, 6'h0, nosr, 1'b0, d});
      @(posedge clk);
      c3_req <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (mem_cke_low !== 1'b1 && mem_self_refresh !== 1'b1 && n < 40);
      check("c3_delay", n, (ecke | esr) ? d + 3 : 40);
      check("cke_low", mem_cke_low, ecke);
      check("self_ref", mem_self_refresh, esr);
      @(posedge clk);
      c3_req <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check("c3_exit", {mem_cke_low, mem_self_refresh}, 32'h0);
   endtask : c3_run

   // the whole sequence is well under 2000 cycles
   initial begin
      repeat (6000) @(posedge clk);
      failures++;
      complete_run();
   end

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
      c3_req = 1'b0;
      gfx_busy_req = 1'b0;
      gfx_port_mode = 1'b0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1 check("busy_rst", busy_n, 1'b1);
      rchk("c3_reset", OFS_C3_POWER_CONTROL, C3_RESET);
      rchk("mgmt_reset", OFS_MGMT_RAM_GRAPHICS_CONTROL, 32'h0);
      // reserved bits must not store; this write leaves bit 8 at zero
      apb(1'b1, OFS_C3_POWER_CONTROL, 32'hffff_feff);
      rchk("c3_rsvd", OFS_C3_POWER_CONTROL, 32'h0001_06ff);
      repeat (3) @(posedge clk);
      #1 check("busy_force", busy_n, 1'b0);
      apb(1'b1, OFS_C3_POWER_CONTROL, C3_RESET);
      repeat (3) @(posedge clk);
      #1 check("busy_off", busy_n, 1'b1);
      @(posedge clk);
      gfx_busy_req <= 1'b1;
      repeat (6) @(posedge clk);
      #1 check("busy_pin", busy_n, 1'b0);
      @(posedge clk);
      gfx_busy_req <= 1'b0;
      repeat (6) @(posedge clk);
      #1 check("busy_rel", busy_n, 1'b1);
      apb(1'b1, 12'h090, 32'h0000_1234);
      check("wr_err", err, 1'b1);
      apb(1'b0, 12'h090, 32'h0);
      check("rd_err", err, 1'b1);
      check("rd_unmap", rd, 32'h0);
      c3_run(8'h03, 1'b0, 1'b1, 1'b1, 1'b0);
      c3_run(8'h00, 1'b0, 1'b1, 1'b1, 1'b0);
      c3_run(8'h05, 1'b1, 1'b0, 1'b0, 1'b1);
      c3_run(8'h02, 1'b1, 1'b1, 1'b0, 1'b0);
      c3_run(8'h02, 1'b0, 1'b0, 1'b1, 1'b1);
      for (g = 0; g < 4; g++) begin
         for (u = 0; u < 4; u++) begin
            apb(1'b1, OFS_MGMT_RAM_GRAPHICS_CONTROL, {g[1:0], u[1:0], 4'h0});
            repeat (3) @(posedge clk);
            #1 mchk(g[1:0], u[1:0], 1'b0);
         end
      end
      // graphics-port mode overrides the mode field
      @(posedge clk);
      gfx_port_mode <= 1'b1;
      apb(1'b1, OFS_MGMT_RAM_GRAPHICS_CONTROL, 32'h0000_00f0);
      repeat (3) @(posedge clk);
      #1 mchk(2'b11, 2'b11, 1'b1);
      apb(1'b0, OFS_BLOCK_STATUS, 32'h0);
      check("port_mode", rd[0], 1'b1);
      @(posedge clk);
      gfx_port_mode <= 1'b0;
      apb(1'b1, OFS_MGMT_RAM_GRAPHICS_CONTROL, 32'h0000_0080);
      apb(1'b0, OFS_BLOCK_STATUS, 32'h0);
      check("port_stay", rd[0], 1'b0);
      // lock, then try to change the frozen fields
      apb(1'b1, OFS_MGMT_RAM_GRAPHICS_CONTROL, 32'h0000_00aa);
      apb(1'b1, OFS_MGMT_RAM_GRAPHICS_CONTROL, 32'h0000_0044);
      rchk("mgmt_lock", OFS_MGMT_RAM_GRAPHICS_CONTROL, 32'h0000_00a6);
      repeat (3) @(posedge clk);
      #1 mchk(2'b10, 2'b10, 1'b0);
      complete_run();
   end
endmodule : c3_power_and_gfx_memory_config_test
